// *** mode_ctl_asserts.sv ***
`timescale 1ns/1ps
module mode_ctl_asserts #(
	parameter int FREQ_W = 32
) (
	// Clock and reset
	input wire logic              i_core_clk,
	input wire logic              i_nrst,
	// Watched ports
	input wire logic              i_valid_avail,
	input wire logic              o_hreadyout,
	input wire logic              o_out_clk_en,
	input wire logic              o_lock_loss_indicator,
	input wire logic [3:0]        o_mode,
	input wire logic              o_fastlock_active,
	input wire logic              o_ext_ref_sel,
	input wire logic              o_xtal_load_cap_en,
	input wire logic [FREQ_W-1:0] o_freq_offset
);
	localparam logic [3:0] FRUN = pll_ctl_pkg::MODE_FREERUN;
	localparam logic [3:0] ACQ  = pll_ctl_pkg::MODE_ACQUIRE;
	localparam logic [3:0] LCK  = pll_ctl_pkg::MODE_LOCKED;
	localparam logic [3:0] HOLD = pll_ctl_pkg::MODE_HOLDOVER;
	// Steps barred here
	wire barred = o_mode == ACQ || o_mode == HOLD;

	default clocking cb @(posedge i_core_clk);
	endclocking
	default disable iff (!i_nrst);

	init_stall_a: assert property ($rose(i_nrst) |-> !o_hreadyout && !o_out_clk_en)
		else $error("host or clocks open straight after reset");
	clk_gate_a: assert property (o_out_clk_en == o_hreadyout)
		else $error("output clocks and host access disagree");
	one_mode_a: assert property ($onehot(o_mode))
		else $error("loop mode not one-hot");
	init_freerun_a: assert property (!o_out_clk_en |-> o_mode == FRUN)
		else $error("mode left free-run during init");
	acq_start_a: assert property (o_out_clk_en && o_mode == FRUN && i_valid_avail |=> o_mode == ACQ)
		else $error("no acquisition on valid input");
	hold_enter_a: assert property ((o_mode == ACQ || o_mode == LCK) && !i_valid_avail |=> o_mode == HOLD)
		else $error("no holdover on input loss");
	hold_leave_a: assert property (o_mode == HOLD && i_valid_avail |=> o_mode == ACQ)
		else $error("holdover not left on valid input");
	fast_off_a: assert property (o_mode == LCK [*2] |-> !o_fastlock_active)
		else $error("fastlock bandwidth kept while locked");
	loss_pull_a: assert property (o_mode == ACQ [*2] |-> o_lock_loss_indicator)
		else $error("lock loss cleared during pull-in");
	lock_show_a: assert property (o_mode == LCK [*2] |-> !o_lock_loss_indicator)
		else $error("lock loss shown while locked");
	cap_off_a: assert property (o_out_clk_en |-> o_xtal_load_cap_en != o_ext_ref_sel)
		else $error("load caps wrong for oscillator source");
	step_hold_a: assert property (barred [*3] |-> $stable(o_freq_offset))
		else $error("offset moved in barred mode");
endmodule : mode_ctl_asserts

bind pll_mode_holdover_control mode_ctl_asserts #(.FREQ_W(FREQ_W)) chk (
	.i_core_clk, .i_nrst, .i_valid_avail, .o_hreadyout, .o_out_clk_en, .o_lock_loss_indicator, .o_mode,
	.o_fastlock_active, .o_ext_ref_sel, .o_xtal_load_cap_en, .o_freq_offset);

// *** pll_ctl_pkg.sv ***
// Contract
// - Load defaults at power-up, stall host until done
// - Output clocks held off until init done
// - Pin or bit hard reset reloads everything
// - Soft reset only applies pending configuration
// - Exactly one of four loop modes
// - Enter free-run automatically after init
// - Start acquisition when any input valid
// - Fastlock bandwidth during acquisition only
// - Normal loop bandwidth register selectable
// - Fastlock bandwidth register selectable
// - Lock shown on pin and status bit
// - Holdover when no valid input remains
// - Record frequency history while locked
// - Average window with delay exclusion
// - Steer to averaged frequency in holdover
// - Leave holdover when input returns, reacquire
// - Ramped exit at selected linear rate
// - Unramped exit uses loop or exit bandwidth; code uses fastlock, not loop, when fastlock is on and exit bandwidth off
// - Oscillator source select, load caps off
// - Reference prescale divider provided
// - Step up adds word, down subtracts
// - Steps allowed only free-run or locked
// - Lock loss stays set during pull-in
package pll_ctl_pkg;
	localparam logic [7:0] REG_CTRL     = 8'h00;
	localparam logic [7:0] REG_BW       = 8'h04;
	localparam logic [7:0] REG_HOLD     = 8'h08;
	localparam logic [7:0] REG_PRESCALE = 8'h0C;
	localparam logic [7:0] REG_STEP     = 8'h10;
	localparam logic [7:0] REG_STATUS   = 8'h14;
	localparam logic [7:0] REG_OFFSET   = 8'h18;
	localparam logic [7:0] REG_HOLDFREQ = 8'h1C;

	localparam int CTRL_HARD_RST  = 0;
	localparam int CTRL_SOFT_RST  = 1;
	localparam int CTRL_FASTLOCK  = 2;
	localparam int CTRL_RAMP_EXIT = 3;
	localparam int CTRL_EXIT_BW   = 4;
	localparam int CTRL_EXT_REF   = 5;
	localparam int CTRL_STEP_MODE = 6;
	localparam int CTRL_STEP_UP   = 7;
	localparam int CTRL_STEP_DN   = 8;
	localparam logic [31:0] CTRL_STORE_MASK = 32'h0000_007C;

	// Field positions: bandwidth codes, holdover settings and status bits
	localparam int BW_LOOP_LSB = 0;
	localparam int BW_FAST_LSB = 8;
	localparam int BW_EXIT_LSB = 16;
	localparam int HOLD_WIN_LSB   = 0;
	localparam int HOLD_DELAY_LSB = 8;
	localparam int HOLD_RATE_LSB  = 16;
	localparam int STAT_LOCK      = 4;
	localparam int STAT_HOLD_OK   = 5;
	localparam int STAT_RAMP      = 6;

	// Non-volatile defaults restored by every hard reset
	localparam logic [31:0] NVM_CTRL     = 32'h0000_000C;
	localparam logic [31:0] NVM_BW       = 32'h0004_1002;
	localparam logic [31:0] NVM_HOLD     = 32'h0004_0103;
	localparam logic [31:0] NVM_PRESCALE = 32'h0000_0001;
	localparam logic [31:0] NVM_STEP     = 32'h0000_0001;

	localparam logic [4:0]  RAMP_RATE_MAX = 5'h11;
	localparam logic [31:0] RAMP_BASE     = 32'h0000_0001;

	localparam int CLK_HZ           = 40_000_000;
	localparam int INIT_TIME_US     = 10;
	localparam int INIT_CYCLES      = CLK_HZ / 1_000_000 * INIT_TIME_US;
	localparam int HIST_SAMPLE_MS   = 1000;
	localparam int SAMPLE_CYCLES    = CLK_HZ / 1000 * HIST_SAMPLE_MS;
	localparam int HIST_SECONDS     = 120;
	localparam int HIST_DEPTH       = HIST_SECONDS * 1000 / HIST_SAMPLE_MS;
	localparam int RAMP_TICK_US     = 1000;
	localparam int RAMP_TICK_CYCLES = CLK_HZ / 1_000_000 * RAMP_TICK_US;

	typedef enum logic [3:0] {
		MODE_FREERUN  = 4'b0001,
		MODE_ACQUIRE  = 4'b0010,
		MODE_LOCKED   = 4'b0100,
		MODE_HOLDOVER = 4'b1000
	} loop_mode_t;
endpackage : pll_ctl_pkg

// *** pll_mode_holdover_control.sv ***
// Decided for this implementation: the address map and register access over AHB-Lite.
`timescale 1ns/1ps
module pll_mode_holdover_control #(
	parameter int FREQ_W           = 32,
	parameter int HIST_DEPTH       = pll_ctl_pkg::HIST_DEPTH,
	parameter int SAMPLE_CYCLES    = pll_ctl_pkg::SAMPLE_CYCLES,
	parameter int RAMP_TICK_CYCLES = pll_ctl_pkg::RAMP_TICK_CYCLES
) (
	// Clock and reset
	input  wire logic              i_core_clk,
	input  wire logic              i_nrst,
	// Pins
	input  wire logic              i_hard_reset_pin_n,
	input  wire logic              i_freq_step_up,
	input  wire logic              i_freq_step_down,
	// Loop status, same clock
	input  wire logic              i_valid_avail,
	input  wire logic              i_lock_detect,
	input  wire logic [FREQ_W-1:0] i_freq_meas,
	// AHB-Lite slave
	input  wire logic              i_hsel,
	input  wire logic [31:0]       i_haddr,
	input  wire logic [1:0]        i_htrans,
	input  wire logic              i_hwrite,
	input  wire logic [2:0]        i_hsize,
	input  wire logic [31:0]       i_hwdata,
	input  wire logic              i_hready,
	output logic                   o_hreadyout,
	output logic [31:0]            o_hrdata,
	output logic                   o_hresp,
	// Loop control
	output logic                   o_out_clk_en,
	output logic                   o_lock_loss_indicator,
	output logic [3:0]             o_mode,
	output logic [7:0]             o_loop_bw_code,
	output logic                   o_fastlock_active,
	output logic                   o_ext_ref_sel,
	output logic                   o_xtal_load_cap_en,
	output logic [7:0]             o_ref_prescale_divider,
	output logic                   o_steer_en,
	output logic [FREQ_W-1:0]      o_steer_freq,
	output logic [FREQ_W-1:0]      o_freq_offset
);
	localparam int PTR_W = $clog2(HIST_DEPTH);
	localparam int SUM_W = FREQ_W + 8;
	localparam int SC_W  = $clog2(SAMPLE_CYCLES);
	localparam int RT_W  = $clog2(RAMP_TICK_CYCLES);
	localparam int IC_W  = $clog2(pll_ctl_pkg::INIT_CYCLES);

	generate
		if (FREQ_W < 16 || FREQ_W > 32 || HIST_DEPTH < 2 || HIST_DEPTH > 255 ||
			SAMPLE_CYCLES < 2 || RAMP_TICK_CYCLES < 2) begin : g_bad_params
			$error("pll_mode_holdover_control: unsupported parameter values");
		end
	endgenerate

	function automatic logic [PTR_W-1:0] idx_back(input logic [PTR_W-1:0] idx, input int n);
		int r;
		r = int'(idx) - n;
		if (r < 0)
			r = r + HIST_DEPTH;
		return PTR_W'(r);
	endfunction : idx_back

	// Pin synchronisers
	logic       rst_s1, rst_s2;
	logic [2:0] up_s, dn_s;
	logic       hr_req;
	logic       hard_rst;

	always_ff @(posedge i_core_clk) begin
		if (!i_nrst) begin
			rst_s1 <= 1'b1;
			rst_s2 <= 1'b1;
			up_s   <= 3'h0;
			dn_s   <= 3'h0;
		end else begin
			rst_s1 <= i_hard_reset_pin_n;
			rst_s2 <= rst_s1;
			up_s   <= {up_s[1:0], i_freq_step_up};
			dn_s   <= {dn_s[1:0], i_freq_step_down};
		end
	end

	assign hard_rst = !i_nrst || !rst_s2 || hr_req;

	// Initialisation from non-volatile defaults
	logic [IC_W-1:0] init_cnt;
	logic            init_done;
	wire             init_end = init_cnt == IC_W'(pll_ctl_pkg::INIT_CYCLES - 1);

	always_ff @(posedge i_core_clk) begin
		if (hard_rst) begin
			init_cnt  <= '0;
			init_done <= 1'b0;
		end else if (!init_done) begin
			init_cnt  <= init_cnt + 1'b1;
			init_done <= init_end;
		end
	end

	// Bus slave
	logic        wr_pend;
	logic [7:0]  wr_addr;
	logic [31:0] ctrl_pend, bw_pend, hold_pend, pre_pend;
	logic [31:0] ctrl_act, bw_act, hold_act, pre_act, step_word;
	logic        soft_req;
	wire         acc      = i_hsel && i_hready && i_htrans[1] && o_hreadyout;
	wire         wr_do    = wr_pend;
	wire         wr_ctrl  = wr_do && wr_addr == pll_ctl_pkg::REG_CTRL;
	wire         sw_up    = wr_ctrl && i_hwdata[pll_ctl_pkg::CTRL_STEP_UP];
	wire         sw_dn    = wr_ctrl && i_hwdata[pll_ctl_pkg::CTRL_STEP_DN];
	wire  [7:0]  rd_addr  = i_haddr[7:0];
	wire         mapped   = i_haddr[31:8] == 24'h00_0000;

	pll_ctl_pkg::loop_mode_t mode, next_mode;
	logic              ramp_active, hold_valid;
	logic [FREQ_W-1:0] hold_freq, offset;
	logic [31:0]       status_word;
	logic [31:0]       rd_mux;

	assign status_word = {25'h0, ramp_active, hold_valid, mode == pll_ctl_pkg::MODE_LOCKED, mode};

	always_comb begin
		unique case (rd_addr)
			pll_ctl_pkg::REG_CTRL:     rd_mux = ctrl_pend;
			pll_ctl_pkg::REG_BW:       rd_mux = bw_pend;
			pll_ctl_pkg::REG_HOLD:     rd_mux = hold_pend;
			pll_ctl_pkg::REG_PRESCALE: rd_mux = pre_pend;
			pll_ctl_pkg::REG_STEP:     rd_mux = step_word;
			pll_ctl_pkg::REG_STATUS:   rd_mux = status_word;
			pll_ctl_pkg::REG_OFFSET:   rd_mux = 32'(offset);
			pll_ctl_pkg::REG_HOLDFREQ: rd_mux = 32'(hold_freq);
			default:                   rd_mux = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge i_core_clk) begin
		if (hard_rst) begin
			wr_pend     <= 1'b0;
			wr_addr     <= 8'h00;
			o_hrdata    <= 32'h0000_0000;
			o_hreadyout <= 1'b0;
			o_hresp     <= 1'b0;
		end else begin
			o_hreadyout <= init_done;
			wr_pend     <= acc && i_hwrite && mapped && i_hsize == 3'h2;
			wr_addr     <= rd_addr;
			if (acc && !i_hwrite)
				o_hrdata <= mapped ? rd_mux : 32'h0000_0000;
		end
	end

	// Pending configuration and the copy the loop really uses
	always_ff @(posedge i_core_clk) begin
		if (hard_rst) begin
			ctrl_pend <= pll_ctl_pkg::NVM_CTRL;
			bw_pend   <= pll_ctl_pkg::NVM_BW;
			hold_pend <= pll_ctl_pkg::NVM_HOLD;
			pre_pend  <= pll_ctl_pkg::NVM_PRESCALE;
			ctrl_act  <= pll_ctl_pkg::NVM_CTRL;
			bw_act    <= pll_ctl_pkg::NVM_BW;
			hold_act  <= pll_ctl_pkg::NVM_HOLD;
			pre_act   <= pll_ctl_pkg::NVM_PRESCALE;
			step_word <= pll_ctl_pkg::NVM_STEP;
			soft_req  <= 1'b0;
			hr_req    <= 1'b0;
		end else begin
			soft_req <= wr_ctrl && i_hwdata[pll_ctl_pkg::CTRL_SOFT_RST];
			hr_req   <= wr_ctrl && i_hwdata[pll_ctl_pkg::CTRL_HARD_RST];
			if (wr_ctrl)
				ctrl_pend <= i_hwdata & pll_ctl_pkg::CTRL_STORE_MASK;
			if (wr_do && wr_addr == pll_ctl_pkg::REG_BW)
				bw_pend <= {8'h00, i_hwdata[23:0]};
			if (wr_do && wr_addr == pll_ctl_pkg::REG_HOLD)
				hold_pend <= {11'h000, i_hwdata[20:16], i_hwdata[15:8], 5'h00, i_hwdata[2:0]};
			if (wr_do && wr_addr == pll_ctl_pkg::REG_PRESCALE)
				pre_pend <= {24'h00_0000, i_hwdata[7:0]};
			if (wr_do && wr_addr == pll_ctl_pkg::REG_STEP)
				step_word <= i_hwdata;
			// No reload from defaults here, only pending values take effect
			if (soft_req) begin
				ctrl_act <= ctrl_pend;
				bw_act   <= bw_pend;
				hold_act <= hold_pend;
				pre_act  <= pre_pend;
			end
		end
	end

	wire       fastlock_en = ctrl_act[pll_ctl_pkg::CTRL_FASTLOCK];
	wire       ramp_en     = ctrl_act[pll_ctl_pkg::CTRL_RAMP_EXIT];
	wire       exit_bw_sel = ctrl_act[pll_ctl_pkg::CTRL_EXIT_BW];
	wire       step_mode   = ctrl_act[pll_ctl_pkg::CTRL_STEP_MODE];
	wire [7:0] bw_loop     = bw_act[pll_ctl_pkg::BW_LOOP_LSB +: 8];
	wire [7:0] bw_fast     = bw_act[pll_ctl_pkg::BW_FAST_LSB +: 8];
	wire [7:0] bw_exit     = bw_act[pll_ctl_pkg::BW_EXIT_LSB +: 8];
	wire [2:0] win_log2    = hold_act[pll_ctl_pkg::HOLD_WIN_LSB +: 3];
	wire [7:0] hold_delay  = hold_act[pll_ctl_pkg::HOLD_DELAY_LSB +: 8];
	wire [4:0] rate_code   = hold_act[pll_ctl_pkg::HOLD_RATE_LSB +: 5];

	// Loop mode sequencing
	logic [PTR_W:0] hist_fill;

	always_comb begin
		next_mode = mode;
		if (init_done) begin
			unique case (mode)
				pll_ctl_pkg::MODE_FREERUN:
					if (i_valid_avail)
						next_mode = pll_ctl_pkg::MODE_ACQUIRE;
				pll_ctl_pkg::MODE_ACQUIRE:
					if (!i_valid_avail)
						next_mode = pll_ctl_pkg::MODE_HOLDOVER;
					else if (i_lock_detect && !ramp_active)
						next_mode = pll_ctl_pkg::MODE_LOCKED;
				pll_ctl_pkg::MODE_LOCKED:
					if (!i_valid_avail)
						next_mode = pll_ctl_pkg::MODE_HOLDOVER;
					else if (!i_lock_detect)
						next_mode = pll_ctl_pkg::MODE_ACQUIRE;
				pll_ctl_pkg::MODE_HOLDOVER:
					if (i_valid_avail)
						next_mode = pll_ctl_pkg::MODE_ACQUIRE;
				default:
					next_mode = pll_ctl_pkg::MODE_FREERUN;
			endcase
		end
	end

	wire enter_hold = next_mode == pll_ctl_pkg::MODE_HOLDOVER && mode != pll_ctl_pkg::MODE_HOLDOVER;
	wire exit_hold  = mode == pll_ctl_pkg::MODE_HOLDOVER && next_mode == pll_ctl_pkg::MODE_ACQUIRE;
	wire is_locked  = mode == pll_ctl_pkg::MODE_LOCKED;
	wire is_acq     = mode == pll_ctl_pkg::MODE_ACQUIRE;

	always_ff @(posedge i_core_clk) begin
		if (hard_rst)
			mode <= pll_ctl_pkg::MODE_FREERUN;
		else
			mode <= next_mode;
	end

	// History of frequency samples, one per sample period while locked
	logic [FREQ_W-1:0] hist [HIST_DEPTH];
	logic [PTR_W-1:0]  wr_ptr;
	logic [SC_W-1:0]   samp_cnt;
	wire               samp_tick = samp_cnt == SC_W'(SAMPLE_CYCLES - 1);

	always_ff @(posedge i_core_clk) begin
		if (hard_rst) begin
			samp_cnt  <= '0;
			wr_ptr    <= '0;
			hist_fill <= '0;
		end else begin
			samp_cnt <= samp_tick ? '0 : samp_cnt + 1'b1;
			if (samp_tick && is_locked) begin
				wr_ptr <= wr_ptr == PTR_W'(HIST_DEPTH - 1) ? '0 : wr_ptr + 1'b1;
				if (hist_fill != (PTR_W + 1)'(HIST_DEPTH))
					hist_fill <= hist_fill + 1'b1;
			end
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (samp_tick && is_locked)
			hist[wr_ptr] <= i_freq_meas;
	end

	// Window average, one sample per cycle, skipping the delay
	logic             avg_busy;
	logic [PTR_W-1:0] avg_idx;
	logic [7:0]       avg_left;
	logic [SUM_W-1:0] avg_sum;
	wire  [7:0]       win_len  = 8'h01 << win_log2;
	wire  [9:0]       need     = {2'b00, win_len} + {2'b00, hold_delay};
	wire              hist_ok  = need <= 10'(hist_fill);

	always_ff @(posedge i_core_clk) begin
		if (hard_rst) begin
			avg_busy   <= 1'b0;
			avg_idx    <= '0;
			avg_left   <= 8'h00;
			avg_sum    <= '0;
			hold_valid <= 1'b0;
			hold_freq  <= '0;
		end else if (enter_hold) begin
			avg_busy   <= hist_ok;
			avg_idx    <= idx_back(wr_ptr, 1 + int'(hold_delay));
			avg_left   <= win_len;
			avg_sum    <= '0;
			hold_valid <= !hist_ok;
			// Too little history: hold the last measured frequency
			if (!hist_ok)
				hold_freq <= i_freq_meas;
		end else if (avg_busy) begin
			avg_sum  <= avg_sum + SUM_W'(hist[avg_idx]);
			avg_idx  <= idx_back(avg_idx, 1);
			avg_left <= avg_left - 1'b1;
			if (avg_left == 8'h00) begin
				avg_busy   <= 1'b0;
				hold_valid <= 1'b1;
				hold_freq  <= FREQ_W'(avg_sum >> win_log2);
			end
		end else if (is_locked) begin
			hold_valid <= 1'b0;
		end
	end

	// Ramped holdover exit, rate independent of loop bandwidth
	logic [RT_W-1:0]   ramp_cnt;
	logic [FREQ_W-1:0] ramp_val, ramp_target;
	logic              exit_unramped;
	wire               ramp_tick = ramp_cnt == RT_W'(RAMP_TICK_CYCLES - 1);
	wire  [4:0]        rate_sel  = rate_code > pll_ctl_pkg::RAMP_RATE_MAX ? pll_ctl_pkg::RAMP_RATE_MAX : rate_code;
	wire  [FREQ_W-1:0] ramp_step = FREQ_W'(pll_ctl_pkg::RAMP_BASE << rate_sel);
	wire               ramp_up   = ramp_target > ramp_val;
	wire  [FREQ_W-1:0] ramp_gap  = ramp_up ? ramp_target - ramp_val : ramp_val - ramp_target;

	always_ff @(posedge i_core_clk) begin
		if (hard_rst) begin
			ramp_cnt      <= '0;
			ramp_active   <= 1'b0;
			ramp_val      <= '0;
			ramp_target   <= '0;
			exit_unramped <= 1'b0;
		end else begin
			ramp_cnt <= ramp_tick ? '0 : ramp_cnt + 1'b1;
			if (exit_hold) begin
				ramp_active   <= ramp_en && hold_valid;
				ramp_val      <= hold_freq;
				ramp_target   <= i_freq_meas;
				exit_unramped <= !ramp_en;
			end else if (ramp_active && ramp_tick) begin
				if (ramp_gap <= ramp_step) begin
					ramp_val    <= ramp_target;
					ramp_active <= 1'b0;
				end else begin
					ramp_val <= ramp_up ? ramp_val + ramp_step : ramp_val - ramp_step;
				end
			end
			if (!is_acq && !exit_hold)
				exit_unramped <= 1'b0;
		end
	end

	// Step-wise frequency adjustment
	wire up_req  = (up_s[1] && !up_s[2]) || sw_up;
	wire dn_req  = (dn_s[1] && !dn_s[2]) || sw_dn;
	wire step_ok = step_mode && init_done && (is_locked || mode == pll_ctl_pkg::MODE_FREERUN);

	always_ff @(posedge i_core_clk) begin
		if (hard_rst)
			offset <= '0;
		else if (step_ok && up_req && !dn_req)
			offset <= offset + FREQ_W'(step_word);
		else if (step_ok && dn_req && !up_req)
			offset <= offset - FREQ_W'(step_word);
	end

	// Output stage, all registered
	wire next_acq  = next_mode == pll_ctl_pkg::MODE_ACQUIRE;
	wire use_exit  = (exit_unramped || (exit_hold && !ramp_en)) && exit_bw_sel;
	wire next_fast = next_acq && fastlock_en && !use_exit;

	always_ff @(posedge i_core_clk) begin
		if (hard_rst) begin
			o_out_clk_en           <= 1'b0;
			o_lock_loss_indicator  <= 1'b1;
			o_mode                 <= pll_ctl_pkg::MODE_FREERUN;
			o_loop_bw_code         <= 8'h00;
			o_fastlock_active      <= 1'b0;
			o_ext_ref_sel          <= 1'b0;
			o_xtal_load_cap_en     <= 1'b0;
			o_ref_prescale_divider <= 8'h00;
			o_steer_en             <= 1'b0;
			o_steer_freq           <= '0;
			o_freq_offset          <= '0;
		end else begin
			o_out_clk_en          <= init_done;
			o_lock_loss_indicator <= next_mode != pll_ctl_pkg::MODE_LOCKED;
			o_mode                <= next_mode;
			o_fastlock_active     <= next_fast;
			if (next_fast)
				o_loop_bw_code <= bw_fast;
			else if (next_acq && use_exit)
				o_loop_bw_code <= bw_exit;
			else
				o_loop_bw_code <= bw_loop;
			o_ext_ref_sel          <= ctrl_act[pll_ctl_pkg::CTRL_EXT_REF];
			o_xtal_load_cap_en     <= !ctrl_act[pll_ctl_pkg::CTRL_EXT_REF];
			o_ref_prescale_divider <= pre_act[7:0];
			o_steer_en             <= ramp_active || (mode == pll_ctl_pkg::MODE_HOLDOVER && hold_valid);
			o_steer_freq           <= ramp_active ? ramp_val : hold_freq;
			o_freq_offset          <= offset;
		end
	end
endmodule : pll_mode_holdover_control

// *** pll_mode_holdover_control_bench.sv ***
`timescale 1ns/1ps
module pll_mode_holdover_control_bench;
	localparam logic [31:0] FREQ = 32'h0001_2340;
	typedef struct packed {logic w; logic [7:0] a; logic [31:0] d; logic [31:0] e;} row_t;
	logic        clk = 1'b0;
	logic        nrst = 1'b0;
	logic        pin_n = 1'b1;
	logic        up = 1'b0;
	logic        dn = 1'b0;
	logic        want = 1'b0;
	logic        hwrite = 1'b0;
	logic [1:0]  htrans = 2'h0;
	logic [31:0] haddr = 32'h0;
	logic [31:0] hwdata = 32'h0;
	logic        valid, lock, ready, resp, clk_en, loss, fast, ext, cap, steer;
	logic [3:0]  mode;
	logic [7:0]  bw, pre;
	logic [31:0] meas, rdata, sfreq, offs, rd;
	int          err_count = 0;
	int          comparisons = 0;
	row_t        rows [11] = '{
		'{1'b0, 8'h00, 32'h0, pll_ctl_pkg::NVM_CTRL}, '{1'b0, 8'h04, 32'h0, pll_ctl_pkg::NVM_BW},
		'{1'b0, 8'h08, 32'h0, pll_ctl_pkg::NVM_HOLD}, '{1'b0, 8'h0C, 32'h0, pll_ctl_pkg::NVM_PRESCALE},
		'{1'b0, 8'h10, 32'h0, pll_ctl_pkg::NVM_STEP}, '{1'b1, 8'h18, 32'hFFFF_FFFF, 32'h0},
		'{1'b0, 8'h18, 32'h0, 32'h0}, '{1'b1, 8'h20, 32'hFFFF_FFFF, 32'h0}, '{1'b0, 8'h20, 32'h0, 32'h0},
		'{1'b1, 8'h10, 32'h5, 32'h0}, '{1'b0, 8'h10, 32'h0, 32'h5}};

	always #12.5 clk = ~clk;

	ref_clock_model #(.FREQ(FREQ)) far (.i_core_clk(clk), .i_nrst(nrst), .i_want_valid(want),
		.o_valid_avail(valid), .o_lock_detect(lock), .o_freq_meas(meas));
	pll_mode_holdover_control #(.SAMPLE_CYCLES(20), .RAMP_TICK_CYCLES(4)) uut (.i_core_clk(clk), .i_nrst(nrst),
		.i_hard_reset_pin_n(pin_n), .i_freq_step_up(up), .i_freq_step_down(dn), .i_valid_avail(valid),
		.i_lock_detect(lock), .i_freq_meas(meas), .i_hsel(1'b1), .i_haddr(haddr), .i_htrans(htrans),
		.i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata), .i_hready(ready), .o_hreadyout(ready),
		.o_hrdata(rdata), .o_hresp(resp), .o_out_clk_en(clk_en), .o_lock_loss_indicator(loss), .o_mode(mode),
		.o_loop_bw_code(bw), .o_fastlock_active(fast), .o_ext_ref_sel(ext), .o_xtal_load_cap_en(cap),
		.o_ref_prescale_divider(pre), .o_steer_en(steer), .o_steer_freq(sfreq), .o_freq_offset(offs));

	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask : cyc

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		comparisons++;
		if (g !== e) begin
			err_count++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
		while (ready !== 1'b1)
			@(posedge clk);
		htrans <= 2'h2;
		haddr <= {24'h0, a};
		hwrite <= w;
		do @(posedge clk); while (ready !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clk); while (ready !== 1'b1);
		rd = rdata;
		chk("resp", 1'b0, resp);
	endtask : ahb

	task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] e);
		ahb(1'b0, a, 32'h0);
		chk(nm, e, rd);
	endtask : rdchk

	// Pin high long enough for the synchroniser to see each edge
	task automatic pulse(input logic u);
		up <= u;
		dn <= !u;
		cyc(3);
		up <= 1'b0;
		dn <= 1'b0;
		cyc(6);
	endtask : pulse

	task automatic conclude;
		$display("comparisons %0d mismatches %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : conclude

	initial begin
		cyc(12);
		nrst <= 1'b1;
		cyc(20);
		chk("ready", 1'b0, ready);
		chk("clk en", 1'b0, clk_en);
		foreach (rows[i]) begin
			ahb(rows[i].w, rows[i].a, rows[i].d);
			if (!rows[i].w)
				chk("reg", rows[i].e, rd);
		end
		chk("mode", pll_ctl_pkg::MODE_FREERUN, mode);
		$display("defaults done");
		ahb(1'b1, 8'h04, 32'h0003_0507);
		ahb(1'b1, 8'h0C, 32'h4);
		ahb(1'b1, 8'h00, 32'h6C);
		cyc(3);
		chk("ext", 1'b0, ext);
		chk("pre", 8'h01, pre);
		ahb(1'b1, 8'h00, 32'h6E);
		cyc(3);
		chk("ext", 1'b1, ext);
		chk("cap", 1'b0, cap);
		chk("pre", 8'h04, pre);
		chk("bw", 8'h07, bw);
		rdchk("bw reg", 8'h04, 32'h0003_0507);
		pulse(1'b1);
		pulse(1'b1);
		pulse(1'b0);
		rdchk("offset reg", 8'h18, 32'h5);
		$display("soft reset and steps done");
		want <= 1'b1;
		cyc(10);
		chk("mode", pll_ctl_pkg::MODE_ACQUIRE, mode);
		chk("fast", 1'b1, fast);
		chk("bw", 8'h05, bw);
		chk("loss", 1'b1, loss);
		cyc(40);
		chk("mode", pll_ctl_pkg::MODE_LOCKED, mode);
		chk("loss", 1'b0, loss);
		chk("bw", 8'h07, bw);
		ahb(1'b0, 8'h14, 32'h0);
		chk("lock bit", 1'b1, rd[4]);
		ahb(1'b1, 8'h00, 32'hEC);
		cyc(4);
		chk("offset", 32'hA, offs);
		cyc(300);
		want <= 1'b0;
		cyc(20);
		chk("mode", pll_ctl_pkg::MODE_HOLDOVER, mode);
		chk("steer", 1'b1, steer);
		chk("steer freq", FREQ, sfreq);
		pulse(1'b1);
		chk("offset", 32'hA, offs);
		want <= 1'b1;
		cyc(4);
		chk("mode", pll_ctl_pkg::MODE_ACQUIRE, mode);
		chk("loss", 1'b1, loss);
		cyc(40);
		chk("mode", pll_ctl_pkg::MODE_LOCKED, mode);
		chk("steer", 1'b0, steer);
		ahb(1'b1, 8'h00, 32'h76);
		want <= 1'b0;
		cyc(20);
		want <= 1'b1;
		cyc(4);
		chk("bw", 8'h03, bw);
		chk("fast", 1'b0, fast);
		$display("mode sequence done");
		want <= 1'b0;
		cyc(4);
		ahb(1'b1, 8'h00, 32'h1);
		cyc(4);
		chk("ready", 1'b0, ready);
		chk("clk en", 1'b0, clk_en);
		rdchk("bw reg", 8'h04, pll_ctl_pkg::NVM_BW);
		chk("pre", 8'h01, pre);
		chk("ext", 1'b0, ext);
		chk("offset", 32'h0, offs);
		chk("mode", pll_ctl_pkg::MODE_FREERUN, mode);
		ahb(1'b1, 8'h0C, 32'h9);
		rdchk("pre reg", 8'h0C, 32'h9);
		pin_n <= 1'b0;
		cyc(5);
		chk("ready", 1'b0, ready);
		pin_n <= 1'b1;
		rdchk("pre reg", 8'h0C, pll_ctl_pkg::NVM_PRESCALE);
		$display("hard resets done");
		conclude();
	end

	initial begin
		cyc(20000);
		err_count++;
		conclude();
	end
endmodule : pll_mode_holdover_control_bench

// *** ref_clock_model.sv ***
`timescale 1ns/1ps
module ref_clock_model #(
	parameter int          LOCK_CYCLES = 30,
	parameter logic [31:0] FREQ        = 32'h0001_0000
) (
	// Clock and control
	input  wire logic   i_core_clk,
	input  wire logic   i_nrst,
	input  wire logic   i_want_valid,
	// Loop status
	output logic        o_valid_avail,
	output logic        o_lock_detect,
	output logic [31:0] o_freq_meas
);
	int cnt = 0;
	always_ff @(posedge i_core_clk) begin
		o_valid_avail <= i_nrst && i_want_valid;
		if (!o_valid_avail)
			cnt <= 0;
		else if (cnt < LOCK_CYCLES)
			cnt <= cnt + 1;
		o_lock_detect <= o_valid_avail && cnt == LOCK_CYCLES;
		// No input clock: measurement is junk, so it toggles
		o_freq_meas <= !i_nrst ? 32'h0 : i_want_valid ? FREQ : ~o_freq_meas;
	end
endmodule : ref_clock_model
